// File: iea_defines.vh
// Constants for the interrupt entry and arbitration block.
// Assumes an 8-bit core with 16-bit addresses and a downward-growing stack.
`ifndef IEA_DEFINES_VH
`define IEA_DEFINES_VH
`define IEA_NSRC 8
`define IEA_SRC_W 3
`define IEA_VEC_SOFT 16'hFFFC
`define IEA_VEC_HW_TOP 16'hFFFA
`define IEA_STACK_BYTES 3'h5
`define IEA_SP_RESET 16'h00FF
`endif

// File: iea_arbiter.v
// Fixed-priority arbiter: lowest index wins.
// Assumes requests already latched and masked by the caller.
`timescale 1ns/100ps
module iea_arbiter #(
  parameter NSRC = 8,
  parameter SW = 3
)(
  input wire [NSRC-1:0] req,
  output reg any,
  output reg [SW-1:0] code
);
  integer i;
  always @*
  begin
    any = 1'b0;
    code = {SW{1'b0}};
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        any = 1'b1;
        code = i[SW-1:0];
      end
    end
  end
endmodule // iea_arbiter

// File: iea_interrupt_entry.v
// Interrupt entry/return sequencer with latched priority arbitration.
// Assumes the core pulses instr_done at each instruction boundary and
// runs the bus cycles this block requests one per cycle.
`timescale 1ns/100ps
`include "iea_defines.vh"
module iea_interrupt_entry #(
  parameter NSRC = `IEA_NSRC,
  parameter SW = `IEA_SRC_W
)(
  input wire clk,
  input wire sys_rst,
  input wire [NSRC-1:0] irq_in,
  input wire [NSRC-1:0] irq_en,
  input wire [NSRC-1:0] irq_ack,
  input wire instr_done,
  input wire software_interrupt_op,
  input wire return_from_interrupt_op,
  input wire mask_clear,
  input wire mask_set,
  input wire [15:0] pc_in,
  input wire [7:0] acc_in,
  input wire [7:0] x_in,
  input wire [7:0] ccr_in,
  input wire [7:0] rd_data,
  output reg [15:0] addr_r,
  output reg [7:0] wr_data_r,
  output reg wr_r,
  output reg rd_r,
  output reg busy_r,
  output reg imask_r,
  output reg [SW-1:0] src_code_r,
  output reg fetch_r,
  output reg [15:0] pc_out_r,
  output reg [7:0] acc_out_r,
  output reg [7:0] x_out_r,
  output reg [7:0] ccr_out_r,
  output reg restore_r,
  output reg [15:0] sp_r
);
  localparam S_IDLE = 5'h01;
  localparam S_PUSH = 5'h02;
  localparam S_VEC = 5'h04;
  localparam S_POP = 5'h08;
  localparam S_PREF = 5'h10;

  reg [NSRC-1:0] sync1_r, sync2_r, pend_r;
  reg [4:0] st_r;
  reg [2:0] cnt_r;
  reg held_r, is_sw_r;
  reg [15:0] pc_save_r;
  reg [7:0] vech_r;
  wire any;
  wire [SW-1:0] code;
  wire [NSRC-1:0] live = pend_r & irq_en;
  wire [15:0] sp_m1 = sp_r - 16'h0001;
  wire [15:0] sp_p1 = sp_r + 16'h0001;
  wire [15:0] vec_hw = `IEA_VEC_HW_TOP - {12'h000, src_code_r, 1'b0};

  iea_arbiter #(.NSRC(NSRC), .SW(SW)) u_arb (
    .req(live),
    .any(any),
    .code(code)
  );

  // Stacked byte order: PCL, PCH, X, A, CCR
  function [7:0] push_byte;
    input [2:0] n;
    input [15:0] pc;
    begin
      case (n)
        3'h0: push_byte = pc[7:0];
        3'h1: push_byte = pc[15:8];
        3'h2: push_byte = x_in;
        3'h3: push_byte = acc_in;
        default: push_byte = ccr_in;
      endcase
    end
  endfunction

  integer k;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= {NSRC{1'b0}};
      sync2_r <= {NSRC{1'b0}};
      pend_r <= {NSRC{1'b0}};
      st_r <= S_IDLE;
      cnt_r <= 3'h0;
      held_r <= 1'b0;
      is_sw_r <= 1'b0;
      pc_save_r <= 16'h0000;
      vech_r <= 8'h00;
      addr_r <= 16'h0000;
      wr_data_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      busy_r <= 1'b0;
      imask_r <= 1'b1;
      src_code_r <= {SW{1'b0}};
      fetch_r <= 1'b0;
      pc_out_r <= 16'h0000;
      acc_out_r <= 8'h00;
      x_out_r <= 8'h00;
      ccr_out_r <= 8'h00;
      restore_r <= 1'b0;
      sp_r <= `IEA_SP_RESET;
    end
    else
    begin
      sync1_r <= irq_in;
      sync2_r <= sync1_r;
      // latch requests; a synced-in request level beats an ack
      for (k = 0; k < NSRC; k = k + 1)
        pend_r[k] <= sync2_r[k] | (pend_r[k] & ~irq_ack[k]);
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      fetch_r <= 1'b0;
      restore_r <= 1'b0;
      if (mask_set)
        imask_r <= 1'b1;
      else if (mask_clear)
      begin
        imask_r <= 1'b0;
        held_r <= 1'b0;
      end
      case (st_r)
        S_IDLE:
        begin
          // act only at an instruction boundary
          if (instr_done)
          begin
            if (software_interrupt_op)
            begin
              st_r <= S_PUSH;
              is_sw_r <= 1'b1;
              busy_r <= 1'b1;
              cnt_r <= 3'h0;
              pc_save_r <= pc_in;
            end
            else if (return_from_interrupt_op)
            begin
              st_r <= S_POP;
              busy_r <= 1'b1;
              cnt_r <= 3'h0;
            end
            // unmasked enabled source, also right after a return
            else if ((held_r | any) & ~imask_r)
            begin
              st_r <= S_PUSH;
              is_sw_r <= 1'b0;
              busy_r <= 1'b1;
              cnt_r <= 3'h0;
              pc_save_r <= pc_in - 16'h0001;
              if (!held_r)
              begin
                src_code_r <= code;
                held_r <= 1'b1;
              end
            end
          end
        end
        S_PUSH:
        begin
          // only PC, X, A, CCR are stacked
          wr_r <= 1'b1;
          addr_r <= sp_r;
          wr_data_r <= push_byte(cnt_r, pc_save_r);
          sp_r <= sp_m1;
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == `IEA_STACK_BYTES - 3'h1)
          begin
            imask_r <= 1'b1;
            st_r <= S_VEC;
            cnt_r <= 3'h0;
          end
        end
        S_VEC:
        begin
          rd_r <= (cnt_r != 3'h2);
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h0)
            addr_r <= is_sw_r ? `IEA_VEC_SOFT : vec_hw;
          else if (cnt_r == 3'h1)
            addr_r <= addr_r + 16'h0001;
          else if (cnt_r == 3'h2)
            vech_r <= rd_data;
          else
          begin
            addr_r <= {vech_r, rd_data};
            pc_out_r <= {vech_r, rd_data};
            fetch_r <= 1'b1;
            if (!is_sw_r)
              held_r <= 1'b0;
            busy_r <= 1'b0;
            st_r <= S_IDLE;
          end
        end
        S_POP:
        begin
          rd_r <= (cnt_r < `IEA_STACK_BYTES);
          if (cnt_r < `IEA_STACK_BYTES)
          begin
            addr_r <= sp_p1;
            sp_r <= sp_p1;
          end
          cnt_r <= cnt_r + 3'h1;
          // Read data lands two edges after its address, as on the vector reads
          case (cnt_r)
            3'h2: ccr_out_r <= rd_data;
            3'h3: acc_out_r <= rd_data;
            3'h4: x_out_r <= rd_data;
            3'h5: pc_out_r[15:8] <= rd_data;
            3'h6:
            begin
              pc_out_r[7:0] <= rd_data;
              imask_r <= ccr_in[3];
              restore_r <= 1'b1;
              st_r <= S_PREF;
            end
            default: ;
          endcase
        end
        S_PREF:
        begin
          addr_r <= pc_out_r;
          rd_r <= 1'b1;
          fetch_r <= 1'b1;
          busy_r <= 1'b0;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule // iea_interrupt_entry

// File: iea_interrupt_entry_chk.sv
// Checker for the interrupt entry block: stacking order, mask, bus order.
// Assumes it is bound onto iea_interrupt_entry.
`timescale 1ns/100ps
module iea_chk (
  input wire clk,
  input wire sys_rst,
  input wire instr_done,
  input wire software_interrupt_op,
  input wire return_from_interrupt_op,
  input wire [15:0] addr_r,
  input wire wr_r,
  input wire rd_r,
  input wire busy_r,
  input wire imask_r,
  input wire fetch_r,
  input wire restore_r,
  input wire [15:0] sp_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_go;
    instr_done && !busy_r;
  endsequence
  sequence s_push;
    wr_r [*5] ##1 rd_r [*2];
  endsequence
  sequence s_pop;
    rd_r [*5] ##1 !rd_r ##1 restore_r ##1 (fetch_r && rd_r);
  endsequence
  chk_soft_enters: assert property (s_go ##0 software_interrupt_op |=> ##1 s_push)
    else $error("software interrupt did not start stacking");
  chk_first_push: assert property (s_go ##0 software_interrupt_op
    |=> ##1 addr_r == $past(sp_r))
    else $error("first push not at stack pointer");
  chk_rti_pops: assert property (s_go ##0 return_from_interrupt_op && !software_interrupt_op
    |=> ##1 s_pop)
    else $error("return did not pop and prefetch");
  chk_push_order: assert property ($rose(wr_r) |-> s_push)
    else $error("entry bus order wrong");
  chk_mask_set: assert property ($rose(wr_r) |-> ##4 imask_r)
    else $error("mask not set after pushes");
  chk_push_down: assert property (wr_r && $past(wr_r) |-> addr_r == $past(addr_r) - 16'h0001)
    else $error("stack pushes not descending");
  chk_on_boundary: assert property ($rose(busy_r) |-> $past(instr_done))
    else $error("sequence started off a boundary");
  chk_masked_idle: assert property (s_go ##0 !software_interrupt_op && !return_from_interrupt_op
    && imask_r |=> !busy_r)
    else $error("masked request was taken");
  chk_end_fetch: assert property ($fell(busy_r) |-> fetch_r || $past(fetch_r))
    else $error("sequence ended without fetch");
endmodule // iea_chk

// File: iea_mem_model.sv
// Bus partner: stack RAM below 8000, fixed vector pattern above.
// Assumes reads answered one cycle after rd.
`timescale 1ns/100ps
module iea_mem_model (
  input wire clk,
  input wire rd,
  input wire wr,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:255];
  initial rdata = 8'h00;
  always @(posedge clk)
  begin
    if (wr && !addr[15])
      mem[addr[7:0]] <= wdata;
    // Idle bus shows inverted data, never a stale value
    rdata <= !rd ? ~rdata : addr[15] ? addr[7:0] ^ 8'h5A : mem[addr[7:0]];
  end
endmodule // iea_mem_model

// File: iea_interrupt_entry_bench.sv
// Bench for iea_interrupt_entry with a memory partner.
// Assumes default parameters: eight sources, source 0 highest.
`timescale 1ns/100ps
module iea_interrupt_entry_bench;
  logic clk, sys_rst, instr_done, sw_op, ret_op, mclr, mset;
  logic [7:0] irq_in, irq_en, irq_ack, acc, x, ccr, rd_data, wd, ao, xo, co;
  logic [15:0] pc, addr, po, sp;
  logic wr, rd, busy, imask, fetch, rst_o;
  logic [2:0] code;
  integer n_fail = 0, check_count = 0;
  iea_interrupt_entry dut (.clk(clk), .sys_rst(sys_rst), .irq_in(irq_in), .irq_en(irq_en),
    .irq_ack(irq_ack), .instr_done(instr_done), .software_interrupt_op(sw_op),
    .return_from_interrupt_op(ret_op), .mask_clear(mclr), .mask_set(mset), .pc_in(pc),
    .acc_in(acc), .x_in(x), .ccr_in(ccr), .rd_data(rd_data), .addr_r(addr), .wr_data_r(wd),
    .wr_r(wr), .rd_r(rd), .busy_r(busy), .imask_r(imask), .src_code_r(code), .fetch_r(fetch),
    .pc_out_r(po), .acc_out_r(ao), .x_out_r(xo), .ccr_out_r(co), .restore_r(rst_o), .sp_r(sp));
  iea_mem_model p (.clk(clk), .rd(rd), .wr(wr), .addr(addr), .wdata(wd), .rdata(rd_data));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task test_done;
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task ck(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task go(input logic s, input logic r);
    integer i;
    @(negedge clk) {instr_done, sw_op, ret_op} = {1'b1, s, r};
    @(negedge clk) {instr_done, sw_op, ret_op} = 3'h0;
    for (i = 0; i < 30 && fetch !== 1'b1; i++) @(negedge clk);
    if (fetch !== 1'b1)
    begin
      n_fail++;
      test_done;
    end
  endtask
  task t_masked;
    // Let the requests pass the synchroniser so the mask is what refuses them
    @(negedge clk) {irq_in, irq_en} = {8'h06, 8'hFF};
    repeat (3) @(negedge clk);
    instr_done = 1;
    @(negedge clk) instr_done = 0;
    ck("busy", busy, 16'h0);
    mclr = 1;
    @(negedge clk) mclr = 0;
    ck("mask clear", imask, 16'h0);
    mset = 1;
    @(negedge clk) mset = 0;
    ck("mask set", imask, 16'h1);
  endtask
  task t_swi_rti;
    go(1, 0);
    ck("soft start", addr, 16'hA6A7);
    ck("pcl", p.mem[8'hFF], 16'h34);
    ck("x slot", p.mem[8'hFD], 16'h3D);
    ck("imask", imask, 16'h1);
    pc = 16'h4321;
    go(0, 1);
    ck("restored pc", po, 16'h1234);
    ck("restored a", ao, 16'h5C);
    ck("restored x", xo, 16'h3D);
    ck("restored ccr", co, 16'hE1);
    ck("restored mask", imask, 16'h0);
    ck("sp back", sp, 16'h00FF);
    ck("prefetch", addr, 16'h1234);
  endtask
  task t_prio_chain;
    go(0, 0);
    ck("winner", code, 16'h1);
    ck("vector", addr, 16'hA2A3);
    ck("hw pc", p.mem[8'hFF], 16'h20);
    // Drop the request first; an ack while it is still synced in would lose
    @(negedge clk) irq_in = 8'h04;
    repeat (3) @(negedge clk);
    irq_ack = 8'h02;
    @(negedge clk) irq_ack = 0;
    go(0, 1);
    ck("hw return pc", po, 16'h4320);
    go(0, 0);
    ck("chained", code, 16'h2);
    ck("chain vector", addr, 16'hACAD);
  endtask
  initial
  begin
    {instr_done, sw_op, ret_op, mclr, mset, irq_in, irq_en, irq_ack} = 0;
    {pc, acc, x, ccr} = {16'h1234, 8'h5C, 8'h3D, 8'hE1};
    sys_rst = 1;
    repeat (6) @(negedge clk);
    sys_rst = 0;
    repeat (3) @(negedge clk);
    t_masked;
    t_swi_rti;
    t_prio_chain;
    test_done;
  end
endmodule // iea_interrupt_entry_bench
bind iea_interrupt_entry iea_chk u_chk (.clk(clk), .sys_rst(sys_rst), .instr_done(instr_done),
  .software_interrupt_op(software_interrupt_op), .addr_r(addr_r), .wr_r(wr_r), .rd_r(rd_r),
  .return_from_interrupt_op(return_from_interrupt_op), .busy_r(busy_r), .imask_r(imask_r),
  .fetch_r(fetch_r), .restore_r(restore_r), .sp_r(sp_r));
